// file: fsp_defines.svh
// Offsets, field positions, reset values and timing counts of the self-programming controller
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map (byte address on the plain register port)
// ----------------------------------------------------------------------------
`define FSP_CTRL_ADDR 4'h0
`define FSP_DATA_LO_ADDR 4'h1
`define FSP_DATA_HI_ADDR 4'h2
`define FSP_PTR_LO_ADDR 4'h3
`define FSP_PTR_HI_ADDR 4'h4
`define FSP_LOCK_ADDR 4'h5

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define FSP_CTL_INTEN 7
`define FSP_CTL_BUSY 6
`define FSP_CTL_REEN 4
`define FSP_CTL_LOCK 3
`define FSP_CTL_PGWR 2
`define FSP_CTL_PGER 1
`define FSP_CTL_EN 0
`define FSP_CMD_ERASE 7'h03
`define FSP_CMD_LOAD 7'h01
`define FSP_CMD_WRITE 7'h05
`define FSP_CMD_LOCK 7'h09
`define FSP_CMD_REEN 7'h11

// ----------------------------------------------------------------------------
// Reset values and read-back pointer values
// ----------------------------------------------------------------------------
`define FSP_LOCK_RESET 8'hFF
`define FSP_PTR_FUSE_LO 16'h0000
`define FSP_PTR_LOCK 16'h0001
`define FSP_PTR_FUSE_EXT 16'h0002
`define FSP_PTR_FUSE_HI 16'h0003

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FSP_STORE_WINDOW 3'd4
`define FSP_LOAD_WINDOW 3'd3
`define FSP_PROG_TIME_NS 4000
`define FSP_CLK_PERIOD_NS 5
`define FSP_PROG_CYCLES (`FSP_PROG_TIME_NS / `FSP_CLK_PERIOD_NS)

`endif

// file: fsp_pkg.sv
// Types shared by the self-programming controller
package fsp_pkg;
    typedef enum logic [1:0] {
        FSP_IDLE = 2'b00,
        FSP_ARMED = 2'b01,
        FSP_BUSY = 2'b11
    } fsp_state_e;
endpackage

// file: fsp_page_buf.sv
// Temporary page buffer with per-word load and whole-buffer clear
`timescale 1ns/1ps
module fsp_page_buf #(
    parameter int WORDS = 128,
    parameter int AW = 7
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic clr,
    input wire logic wr,
    input wire logic [AW-1:0] waddr,
    input wire logic [15:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [15:0] rdata
);
    logic [15:0] mem [WORDS];
    logic [WORDS-1:0] valid_q;

    // ------------------------------------------------------------------------
    // Storage; unloaded words read erased
    // ------------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WORDS; i++) begin : g_word
            always_ff @(posedge clk) begin
                if (srst || clr) begin
                    valid_q[i] <= 1'b0;
                end else if (wr && waddr == AW'(i)) begin
                    valid_q[i] <= 1'b1;
                end
            end
            always_ff @(posedge clk) begin
                if (wr && waddr == AW'(i)) begin
                    mem[i] <= wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 16'hFFFF;
        end else begin
            rdata <= valid_q[raddr] ? mem[raddr] : 16'hFFFF;
        end
    end
endmodule

// file: fsp_ctrl.sv
// Self-programming controller for on-chip program flash
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_ctrl #(
    parameter int WORD_BITS = 7,
    parameter int PAGE_BITS = 9,
    parameter int HALT_PAGE_FIRST = 480,
    parameter int PROG_CYCLES = `FSP_PROG_CYCLES,
    parameter logic [7:0] FUSE_LO = 8'hFF,
    parameter logic [7:0] FUSE_HI = 8'hFF,
    parameter logic [7:0] FUSE_EXT = 8'hFF
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic store_program_instr,
    input wire logic load_program_instr,
    input wire logic eeprom_write_busy_flag,
    output logic [7:0] load_override_data,
    output logic load_override,
    output logic cpu_halt,
    output logic section_read_block,
    output logic irq,
    output logic flash_erase,
    output logic flash_write,
    output logic [PAGE_BITS-1:0] flash_page,
    output logic [15:0] buf_rdata,
    input wire logic [WORD_BITS-1:0] buf_raddr
);
    localparam int CW = $clog2(PROG_CYCLES + 1);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    fsp_pkg::fsp_state_e state_q, state_d;
    logic [6:0] cmd_q;
    logic int_en_q;
    logic busy_q;
    logic [2:0] win_q;
    logic [7:0] dlo_q, dhi_q, plo_q, phi_q;
    logic [7:0] lock_q;
    logic [5:0] lock_data_q;
    logic [CW-1:0] cnt_q;
    logic [1:0] op_q;
    logic halt_q;
    logic [PAGE_BITS-1:0] page_q;
    logic [7:0] rdata_q;
    logic [7:0] ovr_q;
    logic ovr_v_q;

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    wire [15:0] ptr = {phi_q, plo_q};
    wire [WORD_BITS-1:0] ptr_word = ptr[WORD_BITS:1];
    wire [PAGE_BITS-1:0] ptr_page = PAGE_BITS'(ptr >> (WORD_BITS + 1));
    wire ctl_wr = reg_wr && reg_addr == `FSP_CTRL_ADDR;
    // Commands written to the control register are locked out by an EEPROM write
    wire ctl_ok = ctl_wr && !eeprom_write_busy_flag && state_q == fsp_pkg::FSP_IDLE;
    wire [6:0] new_cmd = reg_wdata[6:0];
    wire reen_wr = ctl_ok && new_cmd == `FSP_CMD_REEN;
    wire armed = state_q == fsp_pkg::FSP_ARMED;
    // A store after the window is ignored; the timeout then returns to idle
    wire store_win = win_q < `FSP_STORE_WINDOW;
    wire spm_go = armed && store_program_instr && store_win && !eeprom_write_busy_flag;
    wire is_erase = cmd_q == `FSP_CMD_ERASE;
    wire is_load = cmd_q == `FSP_CMD_LOAD;
    wire is_write = cmd_q == `FSP_CMD_WRITE;
    wire is_lock = cmd_q == `FSP_CMD_LOCK;
    wire lock_read = armed && is_lock && load_program_instr && win_q < `FSP_LOAD_WINDOW
        && !eeprom_write_busy_flag;
    wire long_op = spm_go && (is_erase || is_write || is_lock);
    wire timeout = armed && win_q == `FSP_STORE_WINDOW;
    wire op_done = state_q == fsp_pkg::FSP_BUSY && cnt_q == CW'(1);
    wire halt_tgt = ptr_page >= PAGE_BITS'(HALT_PAGE_FIRST);
    wire buf_load = spm_go && is_load;
    wire buf_clr = (op_done && op_q == 2'd2) || reen_wr;
    wire en_bit = state_q != fsp_pkg::FSP_IDLE;

    // Only pointer values 0 to 3 return fuse or lock bytes; others read unprogrammed
    logic [7:0] rd_mux;
    always_comb begin
        unique case (ptr)
            `FSP_PTR_FUSE_LO: rd_mux = FUSE_LO;
            `FSP_PTR_LOCK: rd_mux = lock_q;
            `FSP_PTR_FUSE_EXT: rd_mux = FUSE_EXT;
            `FSP_PTR_FUSE_HI: rd_mux = FUSE_HI;
            default: rd_mux = 8'hFF;
        endcase
    end

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            fsp_pkg::FSP_IDLE: begin
                if (ctl_ok && new_cmd[0] && new_cmd != `FSP_CMD_REEN) begin
                    state_d = fsp_pkg::FSP_ARMED;
                end
            end
            fsp_pkg::FSP_ARMED: begin
                if (long_op) begin
                    state_d = fsp_pkg::FSP_BUSY;
                end else if (spm_go || lock_read || timeout) begin
                    state_d = fsp_pkg::FSP_IDLE;
                end
            end
            fsp_pkg::FSP_BUSY: begin
                if (op_done) begin
                    state_d = fsp_pkg::FSP_IDLE;
                end
            end
            default: state_d = fsp_pkg::FSP_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= fsp_pkg::FSP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Window counter runs free; it is only read while armed
    always_ff @(posedge clk) begin
        if (srst) begin
            win_q <= 3'd0;
        end else if (ctl_ok) begin
            win_q <= 3'd0;
        end else begin
            win_q <= win_q + 3'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_q <= 7'h00;
        end else if (ctl_ok) begin
            cmd_q <= new_cmd;
        end
    end

    // ------------------------------------------------------------------------
    // Operation tracking
    // ------------------------------------------------------------------------
    // Latch target at start so software may reuse the pointer
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
            lock_data_q <= 6'h3F;
            op_q <= 2'd0;
            halt_q <= 1'b0;
            page_q <= '0;
        end else if (long_op) begin
            cnt_q <= CW'(PROG_CYCLES);
            op_q <= is_erase ? 2'd1 : (is_write ? 2'd2 : 2'd3);
            halt_q <= !is_lock && halt_tgt;
            page_q <= ptr_page;
            lock_data_q <= dlo_q[5:0];
        end else if (state_q == fsp_pkg::FSP_BUSY) begin
            cnt_q <= cnt_q - CW'(1);
            if (op_done) begin
                op_q <= 2'd0;
                halt_q <= 1'b0;
            end
        end
    end

    // Section busy: set by erase/write, cleared only by re-enable
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_q <= 1'b0;
        end else if (long_op && !is_lock) begin
            busy_q <= 1'b1;
        end else if (reen_wr && op_q == 2'd0) begin
            busy_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Lock bits
    // ------------------------------------------------------------------------
    // Zero in data bits program the lock, never unprogram
    always_ff @(posedge clk) begin
        if (srst) begin
            lock_q <= `FSP_LOCK_RESET;
        end else if (op_done && op_q == 2'd3) begin
            lock_q <= {2'b11, lock_q[5:0] & lock_data_q};
        end
    end

    // ------------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------------
    wire dlo_wr = reg_wr && reg_addr == `FSP_DATA_LO_ADDR;
    wire dhi_wr = reg_wr && reg_addr == `FSP_DATA_HI_ADDR;
    wire plo_wr = reg_wr && reg_addr == `FSP_PTR_LO_ADDR;
    wire phi_wr = reg_wr && reg_addr == `FSP_PTR_HI_ADDR;

    // Interrupt enable follows every control write, even a refused one
    always_ff @(posedge clk) begin
        if (srst) begin
            int_en_q <= 1'b0;
        end else if (ctl_wr) begin
            int_en_q <= reg_wdata[`FSP_CTL_INTEN];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dlo_q <= 8'h00;
        end else if (dlo_wr) begin
            dlo_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dhi_q <= 8'h00;
        end else if (dhi_wr) begin
            dhi_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            plo_q <= 8'h00;
        end else if (plo_wr) begin
            plo_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            phi_q <= 8'h00;
        end else if (phi_wr) begin
            phi_q <= reg_wdata;
        end
    end

    logic [7:0] rd_sel;
    always_comb begin
        unique case (reg_addr)
            `FSP_CTRL_ADDR: rd_sel = {int_en_q, busy_q, 1'b0, cmd_q[4:1] & {4{en_bit}}, en_bit};
            `FSP_DATA_LO_ADDR: rd_sel = dlo_q;
            `FSP_DATA_HI_ADDR: rd_sel = dhi_q;
            `FSP_PTR_LO_ADDR: rd_sel = plo_q;
            `FSP_PTR_HI_ADDR: rd_sel = phi_q;
            `FSP_LOCK_ADDR: rd_sel = lock_q;
            default: rd_sel = 8'h00;
        endcase
    end

    // Read data stand for one cycle and drop back to zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rd_sel : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ovr_q <= 8'h00;
        end else begin
            ovr_q <= lock_read ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ovr_v_q <= 1'b0;
        end else begin
            ovr_v_q <= lock_read;
        end
    end

    // ------------------------------------------------------------------------
    // Page buffer; a busy EEPROM write blocks its loads and its re-enable clear
    // ------------------------------------------------------------------------
    fsp_page_buf #(
        .WORDS(1 << WORD_BITS),
        .AW(WORD_BITS)
    ) u_buf (
        .clk(clk),
        .srst(srst),
        .clr(buf_clr),
        .wr(buf_load),
        .waddr(ptr_word),
        .wdata({dhi_q, dlo_q}),
        .raddr(buf_raddr),
        .rdata(buf_rdata)
    );

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign load_override_data = ovr_q;
    assign load_override = ovr_v_q;
    assign cpu_halt = halt_q;
    assign section_read_block = busy_q;
    assign irq = int_en_q && !en_bit;
    assign flash_erase = op_done && op_q == 2'd1;
    assign flash_write = op_done && op_q == 2'd2;
    assign flash_page = page_q;
endmodule

// file: fsp_ctrl_monitor.sv
// Port assertions for the self-programming controller
`timescale 1ns/1ps
module fsp_ctrl_monitor #(
    parameter int PAGE_BITS = 9,
    parameter int HALT_PAGE_FIRST = 480,
    parameter int PROG_CYCLES = 20
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic store_program_instr,
    input wire logic load_program_instr,
    input wire logic eeprom_write_busy_flag,
    input wire logic load_override,
    input wire logic cpu_halt,
    input wire logic section_read_block,
    input wire logic irq,
    input wire logic flash_erase,
    input wire logic flash_write,
    input wire logic [PAGE_BITS-1:0] flash_page
);
    // ----
    // Checks
    // ----
    localparam int OP_MIN = PROG_CYCLES - 4;
    localparam int OP_MAX = PROG_CYCLES + 4;
    wire logic fl_any = flash_erase | flash_write;
    wire logic ctl_wr = reg_wr && reg_addr == 4'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence op_quiet; !fl_any [*8]; endsequence
    sequence op_done; ##[OP_MIN:OP_MAX] fl_any; endsequence
    op_quiet_a: assert property ($rose(section_read_block) |-> op_quiet)
        else $error("flash pulse too early");
    op_length_a: assert property ($rose(section_read_block) |-> op_done)
        else $error("flash pulse missing");
    start_cause_a: assert property ($rose(section_read_block) |->
        $past(store_program_instr) || $past(store_program_instr, 2)) else $error("op unasked");
    ee_block_a: assert property (eeprom_write_busy_flag [*3] ##0 !section_read_block
        |=> !section_read_block) else $error("op during eeprom write");
    busy_hold_a: assert property (section_read_block && !ctl_wr |=> section_read_block)
        else $error("busy flag dropped");
    busy_end_a: assert property (fl_any |-> section_read_block)
        else $error("busy flag low in op");
    halt_irq_a: assert property (cpu_halt |-> !irq)
        else $error("irq during op");
    halt_page_a: assert property (cpu_halt |-> flash_page >= HALT_PAGE_FIRST)
        else $error("halt on other section");
    page_hold_a: assert property (cpu_halt && $past(cpu_halt) |-> $stable(flash_page))
        else $error("page moved in op");
    halt_end_a: assert property ($fell(cpu_halt) |-> $past(fl_any))
        else $error("halt ended early");
    load_cause_a: assert property (load_override |-> $past(load_program_instr))
        else $error("override unasked");
endmodule
bind fsp_ctrl fsp_ctrl_monitor #(.PAGE_BITS(PAGE_BITS), .HALT_PAGE_FIRST(HALT_PAGE_FIRST),
    .PROG_CYCLES(PROG_CYCLES)) fsp_ctrl_monitor_inst (.clk(clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .store_program_instr(store_program_instr),
    .load_program_instr(load_program_instr), .eeprom_write_busy_flag(eeprom_write_busy_flag),
    .load_override(load_override), .cpu_halt(cpu_halt), .section_read_block(section_read_block),
    .irq(irq), .flash_erase(flash_erase), .flash_write(flash_write), .flash_page(flash_page));

// file: fsp_core_model.sv
// Processor core model: register port cycles and timed instruction pulses
`timescale 1ns/1ps
module fsp_core_model (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    input wire logic load_override,
    input wire logic [7:0] load_override_data,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic store_program_instr,
    output logic load_program_instr
);
    // ----
    // Bus cycles
    // ----
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        store_program_instr = 1'b0;
        load_program_instr = 1'b0;
    end
    // Released lines show the inverse so stale values never look valid
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask
    // Gap counts cycles from the command write; slow gaps test the windows
    task automatic spm(input logic [7:0] c, input int gap);
        wr(4'h0, c);
        repeat (gap - 1) @(posedge clk);
        store_program_instr <= 1'b1;
        @(posedge clk);
        store_program_instr <= 1'b0;
    endtask
    task automatic timed_load(input logic [7:0] c, input int gap, output logic ok,
        output logic [7:0] d);
        wr(4'h0, c);
        repeat (gap - 1) @(posedge clk);
        load_program_instr <= 1'b1;
        @(posedge clk);
        load_program_instr <= 1'b0;
        #1 ok = load_override;
        d = load_override_data;
    endtask
endmodule

// file: tb_top.sv
// Self-checking testbench for the self-programming controller
`timescale 1ns/1ps
module tb_top;
    localparam int PROG = 20;
    localparam logic [15:0] FPTR [3] = '{16'h0000, 16'h0003, 16'h0002};
    localparam logic [7:0] FVAL [3] = '{8'h62, 8'hD9, 8'hFD};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic eeprom_write_busy_flag = 1'b0;
    logic [6:0] buf_raddr = 7'h00;
    logic reg_wr, reg_rd, store_program_instr, load_program_instr, load_override;
    logic cpu_halt, section_read_block, irq, flash_erase, flash_write;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, load_override_data;
    logic [8:0] flash_page;
    logic [15:0] buf_rdata;
    int err_total = 0;
    int samples_checked = 0;
    always #2.5 clk = ~clk;
    fsp_core_model fsp_core_model_inst (.clk(clk), .reg_rdata(reg_rdata),
        .load_override(load_override), .load_override_data(load_override_data),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .store_program_instr(store_program_instr), .load_program_instr(load_program_instr));
    fsp_ctrl #(.HALT_PAGE_FIRST(200), .PROG_CYCLES(PROG), .FUSE_LO(8'h62), .FUSE_HI(8'hD9),
        .FUSE_EXT(8'hFD)) fsp_ctrl_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .store_program_instr(store_program_instr), .load_program_instr(load_program_instr),
        .eeprom_write_busy_flag(eeprom_write_busy_flag),
        .load_override_data(load_override_data), .load_override(load_override),
        .cpu_halt(cpu_halt), .section_read_block(section_read_block),
        .irq(irq), .flash_erase(flash_erase), .flash_write(flash_write),
        .flash_page(flash_page), .buf_rdata(buf_rdata), .buf_raddr(buf_raddr));
    // ----
    // Shared tasks
    // ----
    task automatic wrap_up();
        if (err_total == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ptr(input logic [15:0] p);
        fsp_core_model_inst.wr(4'h3, p[7:0]);
        fsp_core_model_inst.wr(4'h4, p[15:8]);
    endtask
    task automatic bufchk(input logic [6:0] i, input logic [15:0] e);
        @(posedge clk);
        buf_raddr <= i;
        @(posedge clk);
        #1 chk("buf_word", e, buf_rdata);
    endtask
    task automatic wait_op(output logic [8:0] pg, output logic [1:0] kind);
        int n;
        for (n = 0; n < PROG + 10; n++) begin
            @(posedge clk);
            #1;
            if ((flash_erase | flash_write) === 1'b1) break;
        end
        pg = flash_page;
        kind = {flash_erase, flash_write};
        if (n == PROG + 10) begin
            err_total++;
            $display("Error op_end expected 1 seen 0");
            wrap_up();
        end
    endtask
    // ----
    // Scenarios
    // ----
    task automatic s_page();
        logic [8:0] pg;
        logic [1:0] kind;
        ptr(16'h030A);
        fsp_core_model_inst.wr(4'h1, 8'h34);
        fsp_core_model_inst.wr(4'h2, 8'h12);
        fsp_core_model_inst.spm(8'h01, 4);
        @(posedge clk);
        eeprom_write_busy_flag <= 1'b1;
        repeat (6) @(posedge clk);
        eeprom_write_busy_flag <= 1'b0;
        ptr(16'h0304);
        fsp_core_model_inst.wr(4'h1, 8'hCD);
        fsp_core_model_inst.wr(4'h2, 8'hAB);
        fsp_core_model_inst.spm(8'h01, 1);
        bufchk(7'h05, 16'h1234);
        bufchk(7'h02, 16'hABCD);
        ptr(16'h0300);
        fsp_core_model_inst.spm(8'h05, 3);
        ptr(16'h7F00);
        #1 chk("halt_other", 16'h0000, {15'h0, cpu_halt});
        wait_op(pg, kind);
        chk("write_page", 16'h0003, {7'h00, pg});
        chk("write_kind", 16'h0001, {14'h0, kind});
        bufchk(7'h05, 16'hFFFF);
        chk("busy_flag", 16'h0001, {15'h0, section_read_block});
        fsp_core_model_inst.wr(4'h0, 8'h11);
        #1 chk("busy_clear", 16'h0000, {15'h0, section_read_block});
    endtask
    task automatic s_erase();
        logic [8:0] pg;
        logic [1:0] kind;
        logic [7:0] d;
        fsp_core_model_inst.wr(4'h0, 8'h80);
        #1 chk("irq_idle", 16'h0001, {15'h0, irq});
        ptr(16'hC80E);
        fsp_core_model_inst.spm(8'h83, 1);
        repeat (2) @(posedge clk);
        #1 chk("halt", 16'h0001, {15'h0, cpu_halt});
        chk("irq_busy", 16'h0000, {15'h0, irq});
        fsp_core_model_inst.rd(4'h0, d);
        chk("ctrl_busy", 16'h00C3, {8'h00, d});
        wait_op(pg, kind);
        chk("erase_page", 16'h00C8, {7'h00, pg});
        chk("erase_kind", 16'h0002, {14'h0, kind});
        @(posedge clk);
        #1 chk("halt_end", 16'h0000, {15'h0, cpu_halt});
        chk("irq_done", 16'h0001, {15'h0, irq});
        fsp_core_model_inst.spm(8'h01, 1);
        bufchk(7'h07, 16'hABCD);
        fsp_core_model_inst.wr(4'h0, 8'h11);
        bufchk(7'h07, 16'hFFFF);
    endtask
    task automatic s_timed();
        logic ok;
        logic [7:0] d;
        fsp_core_model_inst.spm(8'h03, 5);
        repeat (3) @(posedge clk);
        #1 chk("late_store", 16'h0000, {15'h0, section_read_block});
        ptr(16'h0001);
        fsp_core_model_inst.timed_load(8'h09, 4, ok, d);
        chk("late_load", 16'h0000, {15'h0, ok});
        repeat (2) @(posedge clk);
        fsp_core_model_inst.timed_load(8'h00, 1, ok, d);
        chk("plain_load", 16'h0000, {15'h0, ok});
        fsp_core_model_inst.wr(4'h1, 8'hF5);
        fsp_core_model_inst.spm(8'h09, 2);
        repeat (2) @(posedge clk);
        #1 chk("lock_run", 16'h0000, {14'h0, cpu_halt, section_read_block});
        repeat (PROG + 5) @(posedge clk);
        fsp_core_model_inst.rd(4'h5, d);
        chk("lock_reg", 16'h00F5, {8'h00, d});
        fsp_core_model_inst.timed_load(8'h09, 3, ok, d);
        chk("lock_read", 16'h01F5, {7'h00, ok, d});
        @(posedge clk);
        eeprom_write_busy_flag <= 1'b1;
        fsp_core_model_inst.timed_load(8'h09, 1, ok, d);
        chk("ee_read", 16'h0000, {15'h0, ok});
        fsp_core_model_inst.spm(8'h03, 1);
        repeat (2) @(posedge clk);
        #1 chk("ee_prog", 16'h0000, {15'h0, section_read_block});
        @(posedge clk);
        eeprom_write_busy_flag <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            ptr(FPTR[i]);
            fsp_core_model_inst.timed_load(8'h09, i + 1, ok, d);
            chk("fuse_read", {7'h00, 1'b1, FVAL[i]}, {7'h00, ok, d});
        end
    endtask
    initial begin
        logic [7:0] d;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        fsp_core_model_inst.rd(4'h5, d);
        chk("lock_reset", 16'h00FF, {8'h00, d});
        bufchk(7'h00, 16'hFFFF);
        s_page();
        s_erase();
        s_timed();
        wrap_up();
    end
endmodule
